/* cib_pkg.sv */
`default_nettype none
package cib_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int          CIB_NUM_BANKS      = 11;
  localparam logic [7:0]  CIB_LAST_BANK      = 8'h0A;
  localparam int          CIB_IRQ_NUM_W      = 4;
  localparam int          CIB_DMA_W          = 3;

  // ****************************************
  // Index/data pair placement
  // ****************************************
  localparam logic [15:0] CIB_BASE_LOW       = 16'h002E;
  localparam logic [15:0] CIB_BASE_HIGH      = 16'h004E;
  localparam logic [15:0] CIB_DATA_OFFSET    = 16'h0001;

  // ****************************************
  // Configuration register indexes
  // ****************************************
  localparam logic [7:0]  CIB_IDX_BANK       = 8'h07;
  localparam logic [7:0]  CIB_IDX_BANKED_MIN = 8'h30;
  localparam logic [7:0]  CIB_IDX_ACTIVATE   = 8'h30;
  localparam logic [7:0]  CIB_IDX_BASE0_HI   = 8'h60;
  localparam logic [7:0]  CIB_IDX_BASE0_LO   = 8'h61;
  localparam logic [7:0]  CIB_IDX_BASE1_HI   = 8'h62;
  localparam logic [7:0]  CIB_IDX_BASE1_LO   = 8'h63;
  localparam logic [7:0]  CIB_IDX_IRQ_NUM    = 8'h70;
  localparam logic [7:0]  CIB_IDX_IRQ_TYPE   = 8'h71;
  localparam logic [7:0]  CIB_IDX_DMA0       = 8'h74;
  localparam logic [7:0]  CIB_IDX_DMA1       = 8'h75;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int          CIB_ACT_BIT        = 0;
  localparam int          CIB_WAKE_BIT       = 4;
  localparam int          CIB_LEVEL_BIT      = 0;
  localparam int          CIB_HIGH_BIT       = 1;

  // ****************************************
  // Reset and fixed read values
  // ****************************************
  localparam logic [7:0]  CIB_INDEX_RST      = 8'h00;
  localparam logic [7:0]  CIB_BANK_RST       = 8'h00;
  localparam logic [7:0]  CIB_UNIMPL_RD      = 8'h00;
  localparam logic [7:0]  CIB_DMA_UNIMPL_RD  = 8'h04;
  localparam logic [2:0]  CIB_DMA_NONE       = 3'h4;

  typedef enum logic [0:0] {
    CIB_CAP_WAIT = 1'b0,
    CIB_CAP_HELD = 1'b1
  } cib_cap_t;

  // Fixed answer for an index with no register behind it
  function automatic logic [7:0] cib_unimpl_read(input logic [7:0] idx);
    if ((idx == CIB_IDX_DMA0) || (idx == CIB_IDX_DMA1))
    begin
      return CIB_DMA_UNIMPL_RD;
    end
    return CIB_UNIMPL_RD;
  endfunction : cib_unimpl_read

endpackage : cib_pkg
`default_nettype wire

/* cib_strap_capture.sv */
`timescale 1ns/1ps
`default_nettype none
module cib_strap_capture
  import cib_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic configBaseStrap,
  input  wire logic testStrap,
  output logic      baseSel,
  output logic      baseHigh,
  output logic      testMode
);

  cib_cap_t state;
  cib_cap_t next_state;
  logic     next_baseHigh;
  logic     next_testMode;

  // ****************************************
  // Capture at the first edge after release
  // ****************************************
  always_comb
  begin
    next_state    = state;
    next_baseHigh = baseHigh;
    next_testMode = testMode;
    case (state)
      CIB_CAP_WAIT:
      begin
        next_state    = CIB_CAP_HELD;
        next_baseHigh = configBaseStrap;
        next_testMode = testStrap;
      end
      CIB_CAP_HELD:
      begin
        next_state = CIB_CAP_HELD;
      end
      default:
      begin
        next_state = CIB_CAP_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state    <= CIB_CAP_WAIT;
      baseHigh <= 1'b0;
      testMode <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      baseHigh <= next_baseHigh;
      testMode <= next_testMode;
    end
  end

  // Strap level used live until captured, so the pair answers at once
  assign baseSel = (state == CIB_CAP_HELD) ? baseHigh : configBaseStrap;

endmodule : cib_strap_capture
`default_nettype wire

/* cib_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module cib_bank
  import cib_pkg::*;
#(
  parameter bit HAS_DMA = 1'b0
)
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        wrEn,
  input  wire logic [7:0]  regIndex,
  input  wire logic [7:0]  wrData,
  output logic      [7:0]  rdData,
  output logic             active,
  output logic      [15:0] base0,
  output logic      [15:0] base1,
  output logic      [3:0]  irqNum,
  output logic             irqWake,
  output logic             irqLevel,
  output logic             irqHigh,
  output logic      [2:0]  dma0,
  output logic      [2:0]  dma1
);

  logic        next_active;
  logic [15:0] next_base0;
  logic [15:0] next_base1;
  logic [3:0]  next_irqNum;
  logic        next_irqWake;
  logic        next_irqLevel;
  logic        next_irqHigh;
  logic [2:0]  next_dma0;
  logic [2:0]  next_dma1;
  logic        dmaOk;

  // ****************************************
  // Write path
  // ****************************************
  always_comb
  begin
    next_active   = active;
    next_base0    = base0;
    next_base1    = base1;
    next_irqNum   = irqNum;
    next_irqWake  = irqWake;
    next_irqLevel = irqLevel;
    next_irqHigh  = irqHigh;
    next_dma0     = dma0;
    next_dma1     = dma1;
    // Reserved channel codes are dropped rather than stored
    dmaOk         = HAS_DMA && (wrData[2:0] <= CIB_DMA_NONE);
    if (wrEn)
    begin
      case (regIndex)
        CIB_IDX_ACTIVATE: next_active = wrData[CIB_ACT_BIT];
        CIB_IDX_BASE0_HI: next_base0[15:8] = wrData;
        CIB_IDX_BASE0_LO: next_base0[7:0] = wrData;
        CIB_IDX_BASE1_HI: next_base1[15:8] = wrData;
        CIB_IDX_BASE1_LO: next_base1[7:0] = wrData;
        CIB_IDX_IRQ_NUM:
        begin
          next_irqNum  = wrData[CIB_IRQ_NUM_W-1:0];
          next_irqWake = wrData[CIB_WAKE_BIT];
        end
        CIB_IDX_IRQ_TYPE:
        begin
          next_irqLevel = wrData[CIB_LEVEL_BIT];
          next_irqHigh  = wrData[CIB_HIGH_BIT];
        end
        CIB_IDX_DMA0: next_dma0 = dmaOk ? wrData[2:0] : dma0;
        CIB_IDX_DMA1: next_dma1 = dmaOk ? wrData[2:0] : dma1;
        default: next_active = active;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      active   <= 1'b0;
      base0    <= 16'h0000;
      base1    <= 16'h0000;
      irqNum   <= 4'h0;
      irqWake  <= 1'b0;
      irqLevel <= 1'b0;
      irqHigh  <= 1'b0;
      dma0     <= CIB_DMA_NONE;
      dma1     <= CIB_DMA_NONE;
    end
    else
    begin
      active   <= next_active;
      base0    <= next_base0;
      base1    <= next_base1;
      irqNum   <= next_irqNum;
      irqWake  <= next_irqWake;
      irqLevel <= next_irqLevel;
      irqHigh  <= next_irqHigh;
      dma0     <= next_dma0;
      dma1     <= next_dma1;
    end
  end

  // ****************************************
  // Read path, reserved bits as zero
  // ****************************************
  always_comb
  begin
    case (regIndex)
      CIB_IDX_ACTIVATE: rdData = {7'h00, active};
      CIB_IDX_BASE0_HI: rdData = base0[15:8];
      CIB_IDX_BASE0_LO: rdData = base0[7:0];
      CIB_IDX_BASE1_HI: rdData = base1[15:8];
      CIB_IDX_BASE1_LO: rdData = base1[7:0];
      CIB_IDX_IRQ_NUM:  rdData = {3'h0, irqWake, irqNum};
      CIB_IDX_IRQ_TYPE: rdData = {6'h00, irqHigh, irqLevel};
      CIB_IDX_DMA0:     rdData = HAS_DMA ? {5'h00, dma0} : cib_unimpl_read(regIndex);
      CIB_IDX_DMA1:     rdData = HAS_DMA ? {5'h00, dma1} : cib_unimpl_read(regIndex);
      default:          rdData = cib_unimpl_read(regIndex);
    endcase
  end

endmodule : cib_bank
`default_nettype wire

/* cib_config_bank.sv */
// How it works
// - Base strap captured as reset ends, held.
// - Strap low decodes 2Eh/2Fh, high 4Eh/4Fh.
// - Test strap high at reset end: test mode.
// - Eight-bit read/write pointer at base plus zero.
// - Pointer reads last write, 00h after reset.
// - Data port forwards to pointed register only.
// - Index 30h and up reaches selected bank.
// - Index 07h picks bank, 00h to 0Ah valid.
// - Unimplemented: writes dropped, read 00h, 74h/75h 04h.
// - Registers usable right after reset, no wait.
// - Registers read/write, reserved bits read zero.
// - Index 30h bit 0 enables the block.
// - First base: high 60h, low 61h.
// - Second base: high 62h, low 63h.
// - Index 70h bits 3-0 pick IRQ 1-15.
// - Bit 4 set: interrupt also raises wake.
// - Index 71h: bit0 edge/level, bit1 polarity.
// - DMA select: 0-3 channel, 4 none.
// - Inactive block keeps its resources unused.
// - All sixteen address bits compared.
`timescale 1ns/1ps
`default_nettype none
module cib_config_bank
  import cib_pkg::*;
#(
  parameter logic [CIB_NUM_BANKS-1:0] DMA_MASK = 11'h003
)
(
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic                       configBaseStrap,
  input  wire logic                       testStrap,
  input  wire logic [15:0]                ioAddr,
  input  wire logic                       ioWrStb,
  input  wire logic                       ioRdStb,
  input  wire logic [7:0]                 ioWrData,
  input  wire logic [CIB_NUM_BANKS-1:0]   blockIrq,
  output logic      [7:0]                 ioRdData,
  output logic                            ioRdValid,
  output logic                            testMode,
  output logic                            configBaseHigh,
  output logic      [CIB_NUM_BANKS-1:0]   blockActive,
  output logic      [CIB_NUM_BANKS*16-1:0] ioBase0Out,
  output logic      [CIB_NUM_BANKS*16-1:0] ioBase1Out,
  output logic      [CIB_NUM_BANKS*4-1:0] irqLineOut,
  output logic      [CIB_NUM_BANKS-1:0]   irqLevelOut,
  output logic      [CIB_NUM_BANKS-1:0]   irqHighOut,
  output logic      [CIB_NUM_BANKS*3-1:0] dmaChanOut,
  output logic      [CIB_NUM_BANKS-1:0]   wakeEvent
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [7:0]  configPointer;
  logic [7:0]  next_configPointer;
  logic [7:0]  bankNumber;
  logic [7:0]  next_bankNumber;
  logic [7:0]  next_ioRdData;
  logic        next_ioRdValid;
  logic        baseSel;
  logic [15:0] pairBase;
  logic        indexHit;
  logic        dataHit;
  logic        bankValid;
  logic        bankedIdx;
  logic [7:0]  rdMux;

  logic [CIB_NUM_BANKS-1:0]    bankWr;
  logic [7:0]                  bankRd     [CIB_NUM_BANKS];
  logic [CIB_NUM_BANKS-1:0]    bankAct;
  logic [15:0]                 bankBase0  [CIB_NUM_BANKS];
  logic [15:0]                 bankBase1  [CIB_NUM_BANKS];
  logic [3:0]                  bankIrq    [CIB_NUM_BANKS];
  logic [CIB_NUM_BANKS-1:0]    bankWake;
  logic [CIB_NUM_BANKS-1:0]    bankLevel;
  logic [CIB_NUM_BANKS-1:0]    bankHigh;
  logic [2:0]                  bankDma0   [CIB_NUM_BANKS];

  logic [CIB_NUM_BANKS-1:0]    irqPrev;
  logic [CIB_NUM_BANKS-1:0]    next_blockActive;
  logic [CIB_NUM_BANKS*16-1:0] next_ioBase0Out;
  logic [CIB_NUM_BANKS*16-1:0] next_ioBase1Out;
  logic [CIB_NUM_BANKS*4-1:0]  next_irqLineOut;
  logic [CIB_NUM_BANKS-1:0]    next_irqLevelOut;
  logic [CIB_NUM_BANKS-1:0]    next_irqHighOut;
  logic [CIB_NUM_BANKS*3-1:0]  next_dmaChanOut;
  logic [CIB_NUM_BANKS-1:0]    next_wakeEvent;

  // ****************************************
  // Strap capture
  // ****************************************
  cib_strap_capture u_strap (
    .clk             (clk),
    .rst_b           (rst_b),
    .configBaseStrap (configBaseStrap),
    .testStrap       (testStrap),
    .baseSel         (baseSel),
    .baseHigh        (configBaseHigh),
    .testMode        (testMode)
  );

  // ****************************************
  // Address decode
  // ****************************************
  always_comb
  begin
    pairBase  = baseSel ? CIB_BASE_HIGH : CIB_BASE_LOW;
    // Full compare avoids aliasing onto other legacy ports
    indexHit  = (ioAddr == pairBase);
    dataHit   = (ioAddr == (pairBase + CIB_DATA_OFFSET));
    bankValid = (bankNumber <= CIB_LAST_BANK);
    bankedIdx = (configPointer >= CIB_IDX_BANKED_MIN);
  end

  // ****************************************
  // Per-function banks
  // ****************************************
  for (genvar b = 0; b < CIB_NUM_BANKS; b++)
  begin : g_bank
    // Data port has no storage; it only steers strobes
    assign bankWr[b] = ioWrStb && dataHit && bankedIdx && bankValid
                       && (bankNumber[3:0] == 4'(b));

    cib_bank #(
      .HAS_DMA (DMA_MASK[b])
    ) u_bank (
      .clk      (clk),
      .rst_b    (rst_b),
      .wrEn     (bankWr[b]),
      .regIndex (configPointer),
      .wrData   (ioWrData),
      .rdData   (bankRd[b]),
      .active   (bankAct[b]),
      .base0    (bankBase0[b]),
      .base1    (bankBase1[b]),
      .irqNum   (bankIrq[b]),
      .irqWake  (bankWake[b]),
      .irqLevel (bankLevel[b]),
      .irqHigh  (bankHigh[b]),
      .dma0     (bankDma0[b]),
      .dma1     ()
    );
  end

  // ****************************************
  // Pointer, bank number and read port
  // ****************************************
  always_comb
  begin
    next_configPointer = configPointer;
    next_bankNumber    = bankNumber;
    if (ioWrStb && indexHit)
    begin
      next_configPointer = ioWrData;
    end
    if (ioWrStb && dataHit && (configPointer == CIB_IDX_BANK))
    begin
      next_bankNumber = ioWrData;
    end

    if (indexHit)
    begin
      rdMux = configPointer;
    end
    else if (!bankedIdx)
    begin
      rdMux = (configPointer == CIB_IDX_BANK) ? bankNumber : cib_unimpl_read(configPointer);
    end
    else if (bankValid)
    begin
      rdMux = bankRd[bankNumber[3:0]];
    end
    else
    begin
      // Reserved bank numbers behave as an empty bank
      rdMux = cib_unimpl_read(configPointer);
    end

    next_ioRdValid = ioRdStb && (indexHit || dataHit);
    next_ioRdData  = next_ioRdValid ? rdMux : ioRdData;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      configPointer <= CIB_INDEX_RST;
      bankNumber    <= CIB_BANK_RST;
      ioRdData      <= 8'h00;
      ioRdValid     <= 1'b0;
    end
    else
    begin
      configPointer <= next_configPointer;
      bankNumber    <= next_bankNumber;
      ioRdData      <= next_ioRdData;
      ioRdValid     <= next_ioRdValid;
    end
  end

  // ****************************************
  // Resource distribution and wake
  // ****************************************
  always_comb
  begin
    for (int i = 0; i < CIB_NUM_BANKS; i++)
    begin
      // Inactive blocks show no bases, IRQ line or DMA channel; IRQ level and polarity bits still pass through
      next_blockActive[i]       = bankAct[i];
      next_ioBase0Out[i*16+:16] = bankAct[i] ? bankBase0[i] : 16'h0000;
      next_ioBase1Out[i*16+:16] = bankAct[i] ? bankBase1[i] : 16'h0000;
      next_irqLineOut[i*4+:4]   = bankAct[i] ? bankIrq[i] : 4'h0;
      next_irqLevelOut[i]       = bankLevel[i];
      next_irqHighOut[i]        = bankHigh[i];
      next_dmaChanOut[i*3+:3]   = bankAct[i] ? bankDma0[i] : CIB_DMA_NONE;
      // Value 0 selects no line, so it cannot wake either
      next_wakeEvent[i]         = bankAct[i] && bankWake[i] && (bankIrq[i] != 4'h0)
                                  && blockIrq[i] && !irqPrev[i];
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      blockActive <= '0;
      ioBase0Out  <= '0;
      ioBase1Out  <= '0;
      irqLineOut  <= '0;
      irqLevelOut <= '0;
      irqHighOut  <= '0;
      dmaChanOut  <= {CIB_NUM_BANKS{CIB_DMA_NONE}};
      wakeEvent   <= '0;
      irqPrev     <= '0;
    end
    else
    begin
      blockActive <= next_blockActive;
      ioBase0Out  <= next_ioBase0Out;
      ioBase1Out  <= next_ioBase1Out;
      irqLineOut  <= next_irqLineOut;
      irqLevelOut <= next_irqLevelOut;
      irqHighOut  <= next_irqHighOut;
      dmaChanOut  <= next_dmaChanOut;
      wakeEvent   <= next_wakeEvent;
      irqPrev     <= blockIrq;
    end
  end

endmodule : cib_config_bank
`default_nettype wire

/* cib_config_bank_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module cib_config_bank_checker
  import cib_pkg::*;
(
  input wire logic                        clk,
  input wire logic                        rst_b,
  input wire logic                        configBaseStrap,
  input wire logic                        testStrap,
  input wire logic [15:0]                 ioAddr,
  input wire logic                        ioWrStb,
  input wire logic                        ioRdStb,
  input wire logic [7:0]                  ioWrData,
  input wire logic [CIB_NUM_BANKS-1:0]    blockIrq,
  input wire logic [7:0]                  ioRdData,
  input wire logic                        ioRdValid,
  input wire logic                        testMode,
  input wire logic                        configBaseHigh,
  input wire logic [CIB_NUM_BANKS-1:0]    blockActive,
  input wire logic [CIB_NUM_BANKS*16-1:0] ioBase0Out,
  input wire logic [CIB_NUM_BANKS*4-1:0]  irqLineOut,
  input wire logic [CIB_NUM_BANKS*3-1:0]  dmaChanOut,
  input wire logic [CIB_NUM_BANKS-1:0]    wakeEvent
);
  // ****
  // Pair decode and pointer shadow
  // ****
  logic [15:0] base;
  logic        hit;
  logic [7:0]  ptr;
  logic [7:0]  ptrAtRd;
  logic        rdIdx;
  logic        capDone;
  // Live strap decodes until the first edge after reset
  assign base = (capDone ? configBaseHigh : configBaseStrap) ? CIB_BASE_HIGH : CIB_BASE_LOW;
  assign hit  = (ioAddr[15:1] == base[15:1]);
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ptr     <= 8'h00;
      ptrAtRd <= 8'h00;
      rdIdx   <= 1'b0;
      capDone <= 1'b0;
    end
    else
    begin
      if (ioWrStb && hit && !ioAddr[0])
      begin
        ptr <= ioWrData;
      end
      ptrAtRd <= ptr;
      rdIdx   <= ioRdStb && hit && !ioAddr[0];
      capDone <= 1'b1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ****
  // Checks
  // ****
  chk_read_answer: assert property (ioRdStb && hit |=> ioRdValid)
    else $error("read of the pair not answered");
  chk_no_stray: assert property (!(ioRdStb && hit) |=> !ioRdValid)
    else $error("answer without a decoded read");
  chk_index_back: assert property (ioRdValid && rdIdx |-> ioRdData == ptrAtRd)
    else $error("pointer read-back wrong");
  chk_data_hold: assert property (!ioRdValid |-> $stable(ioRdData))
    else $error("read data moved without a read");
  chk_strap_value: assert property (rst_b && $past(rst_b) && !$past(rst_b, 2)
    |-> configBaseHigh == $past(configBaseStrap) && testMode == $past(testStrap))
    else $error("straps not captured at reset end");
  chk_strap_hold: assert property ($past(rst_b) && $past(rst_b, 2)
    |-> $stable(configBaseHigh) && $stable(testMode))
    else $error("strap choice changed");
  chk_wake_cause: assert property (|wakeEvent
    |-> ((wakeEvent & ~$past(blockIrq)) | (wakeEvent & $past(blockIrq, 2))) == '0)
    else $error("wake without interrupt rise");
  chk_idle_outputs: assert property (!$past(blockActive[0]) && !blockActive[0]
    |-> dmaChanOut[2:0] == CIB_DMA_NONE && ioBase0Out[15:0] == 16'h0000
        && irqLineOut[3:0] == 4'h0)
    else $error("inactive bank exports resources");
  chk_dma_absent: assert property (dmaChanOut[8:6] == CIB_DMA_NONE)
    else $error("bank without DMA shows a channel");
  cover property (ioWrStb && hit);
  cover property (ioRdValid && rdIdx);
  cover property (|wakeEvent);
endmodule : cib_config_bank_checker

bind cib_config_bank cib_config_bank_checker i_cib_config_bank_checker (
  .clk(clk), .rst_b(rst_b), .configBaseStrap(configBaseStrap), .testStrap(testStrap),
  .ioAddr(ioAddr), .ioWrStb(ioWrStb), .ioRdStb(ioRdStb), .ioWrData(ioWrData),
  .blockIrq(blockIrq), .ioRdData(ioRdData), .ioRdValid(ioRdValid), .testMode(testMode),
  .configBaseHigh(configBaseHigh), .blockActive(blockActive), .ioBase0Out(ioBase0Out),
  .irqLineOut(irqLineOut), .dmaChanOut(dmaChanOut), .wakeEvent(wakeEvent));
`default_nettype wire

/* cib_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cib_host_model
  import cib_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [7:0]  ioRdData,
  input  wire logic        ioRdValid,
  output logic      [15:0] ioAddr,
  output logic             ioWrStb,
  output logic             ioRdStb,
  output logic      [7:0]  ioWrData
);
  // ****
  // Host I/O cycles
  // ****
  initial
  begin
    ioAddr   <= 16'h0000;
    ioWrStb  <= 1'b0;
    ioRdStb  <= 1'b0;
    ioWrData <= 8'h00;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    ioAddr   <= a;
    ioWrData <= d;
    ioWrStb  <= 1'b1;
    @(posedge clk);
    ioWrStb  <= 1'b0;
    // Released lines carry junk, never the old value
    ioAddr   <= ~a;
    ioWrData <= ~d;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d  = 8'h00;
    @(posedge clk);
    ioAddr  <= a;
    ioRdStb <= 1'b1;
    @(posedge clk);
    ioRdStb <= 1'b0;
    ioAddr  <= ~a;
    for (int i = 0; i < 3 && !ok; i++)
    begin
      @(posedge clk);
      if (ioRdValid === 1'b1)
      begin
        ok = 1'b1;
        d  = ioRdData;
      end
    end
  endtask : rd
endmodule : cib_host_model
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
  import cib_pkg::*;
;
  logic                         clk = 1'b0;
  logic                         rst_b = 1'b0;
  logic                         configBaseStrap = 1'b0;
  logic                         testStrap = 1'b0;
  logic [CIB_NUM_BANKS-1:0]     blockIrq = '0;
  logic [15:0]                  ioAddr;
  logic                         ioWrStb;
  logic                         ioRdStb;
  logic [7:0]                   ioWrData;
  logic [7:0]                   ioRdData;
  logic                         ioRdValid;
  logic                         testMode;
  logic                         configBaseHigh;
  logic [CIB_NUM_BANKS-1:0]     blockActive;
  logic [CIB_NUM_BANKS*16-1:0]  ioBase0Out;
  logic [CIB_NUM_BANKS*16-1:0]  ioBase1Out;
  logic [CIB_NUM_BANKS*4-1:0]   irqLineOut;
  logic [CIB_NUM_BANKS-1:0]     irqLevelOut;
  logic [CIB_NUM_BANKS-1:0]     irqHighOut;
  logic [CIB_NUM_BANKS*3-1:0]   dmaChanOut;
  logic [CIB_NUM_BANKS-1:0]     wakeEvent;
  logic [15:0]                  base = CIB_BASE_LOW;
  int                           mismatches = 0;
  int                           cmpCount = 0;
  always #25 clk = ~clk;
  cib_config_bank i_cib_config_bank (.clk(clk), .rst_b(rst_b), .configBaseStrap(configBaseStrap),
    .testStrap(testStrap), .ioAddr(ioAddr), .ioWrStb(ioWrStb), .ioRdStb(ioRdStb), .ioWrData(ioWrData),
    .blockIrq(blockIrq), .ioRdData(ioRdData), .ioRdValid(ioRdValid), .testMode(testMode),
    .configBaseHigh(configBaseHigh), .blockActive(blockActive), .ioBase0Out(ioBase0Out),
    .ioBase1Out(ioBase1Out), .irqLineOut(irqLineOut), .irqLevelOut(irqLevelOut),
    .irqHighOut(irqHighOut), .dmaChanOut(dmaChanOut), .wakeEvent(wakeEvent));
  cib_host_model i_cib_host_model (.clk(clk), .ioRdData(ioRdData), .ioRdValid(ioRdValid),
    .ioAddr(ioAddr), .ioWrStb(ioWrStb), .ioRdStb(ioRdStb), .ioWrData(ioWrData));
  // ****
  // Helpers
  // ****
  task automatic conclude();
    if (mismatches == 0 && cmpCount > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmpCount++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdAt(input logic [15:0] a, input logic [7:0] exp, input logic expOk);
    logic [7:0] d;
    logic       ok;
    i_cib_host_model.rd(a, d, ok);
    chk({7'h00, ok, expOk ? d : 8'h00}, {7'h00, expOk, exp});
  endtask : rdAt
  task automatic wrreg(input logic [7:0] idx, input logic [7:0] d);
    i_cib_host_model.wr(base, idx);
    i_cib_host_model.wr(base + CIB_DATA_OFFSET, d);
  endtask : wrreg
  task automatic rdreg(input logic [7:0] idx, input logic [7:0] exp);
    i_cib_host_model.wr(base, idx);
    rdAt(base + CIB_DATA_OFFSET, exp, 1'b1);
  endtask : rdreg
  task automatic doReset(input logic bs, input logic ts);
    @(posedge clk);
    rst_b           <= 1'b0;
    configBaseStrap <= bs;
    testStrap       <= ts;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    base = bs ? CIB_BASE_HIGH : CIB_BASE_LOW;
  endtask : doReset
  // ****
  // Scenarios
  // ****
  task automatic tAfterReset();
    rdAt(base, CIB_INDEX_RST, 1'b1);
    rdreg(CIB_IDX_BANK, CIB_BANK_RST);
    chk({14'h0000, testMode, configBaseHigh}, 16'h0000);
  endtask : tAfterReset
  task automatic tIndex();
    i_cib_host_model.wr(base, 8'hA5);
    i_cib_host_model.wr(base ^ 16'h8000, 8'h11);
    rdAt(base ^ 16'h0100, 8'h00, 1'b0);
    rdAt(base, 8'hA5, 1'b1);
  endtask : tIndex
  task automatic tBanks();
    logic [7:0] bk [2] = '{8'h00, 8'h03};
    int         b;
    for (int j = 0; j < 2; j++)
    begin
      wrreg(CIB_IDX_BANK, bk[j]);
      wrreg(CIB_IDX_ACTIVATE, 8'h01);
      wrreg(CIB_IDX_BASE0_HI, 8'h10 + bk[j]);
      wrreg(CIB_IDX_BASE0_LO, 8'h20);
      wrreg(CIB_IDX_BASE1_HI, 8'hC0 + bk[j]);
      wrreg(CIB_IDX_BASE1_LO, 8'h08);
      wrreg(CIB_IDX_IRQ_NUM, 8'h15 + bk[j]);
      wrreg(CIB_IDX_IRQ_TYPE, {6'h00, 1'b1, bk[j][0]});
    end
    for (int j = 0; j < 2; j++)
    begin
      b = bk[j];
      wrreg(CIB_IDX_BANK, bk[j]);
      rdreg(CIB_IDX_BANK, bk[j]);
      rdreg(CIB_IDX_BASE0_HI, 8'h10 + bk[j]);
      rdreg(CIB_IDX_BASE1_HI, 8'hC0 + bk[j]);
      rdreg(CIB_IDX_IRQ_TYPE, {6'h00, 1'b1, bk[j][0]});
      chk({15'h0000, blockActive[b]}, 16'h0001);
      chk(ioBase0Out[b*16+:16], {8'h10 + bk[j], 8'h20});
      chk(ioBase1Out[b*16+:16], {8'hC0 + bk[j], 8'h08});
      chk({12'h000, irqLineOut[b*4+:4]}, 16'h0005 + 16'(b));
      chk({14'h0000, irqHighOut[b], irqLevelOut[b]}, {14'h0000, 1'b1, bk[j][0]});
    end
  endtask : tBanks
  task automatic tUnimpl();
    wrreg(8'h40, 8'h44);
    wrreg(8'h21, 8'h44);
    rdreg(8'h40, CIB_UNIMPL_RD);
    rdreg(8'h21, CIB_UNIMPL_RD);
    rdreg(CIB_IDX_DMA1, CIB_DMA_UNIMPL_RD);
    wrreg(CIB_IDX_BANK, 8'h00);
    wrreg(CIB_IDX_DMA0, 8'h01);
    wrreg(CIB_IDX_DMA0, 8'h06);
    rdreg(CIB_IDX_DMA0, 8'h01);
    chk({13'h0000, dmaChanOut[2:0]}, 16'h0001);
    wrreg(CIB_IDX_BANK, 8'h02);
    wrreg(CIB_IDX_ACTIVATE, 8'h01);
    wrreg(CIB_IDX_DMA0, 8'h01);
    rdreg(CIB_IDX_DMA0, CIB_DMA_UNIMPL_RD);
    chk({13'h0000, dmaChanOut[8:6]}, {13'h0000, CIB_DMA_NONE});
    wrreg(CIB_IDX_BANK, 8'h0B);
    wrreg(CIB_IDX_ACTIVATE, 8'h00);
    rdreg(CIB_IDX_BANK, 8'h0B);
    rdreg(CIB_IDX_ACTIVATE, 8'h00);
    wrreg(CIB_IDX_BANK, 8'h03);
    rdreg(CIB_IDX_ACTIVATE, 8'h01);
    wrreg(CIB_IDX_ACTIVATE, 8'hFF);
    wrreg(CIB_IDX_IRQ_NUM, 8'hFF);
    wrreg(CIB_IDX_IRQ_TYPE, 8'hFF);
    rdreg(CIB_IDX_ACTIVATE, 8'h01);
    rdreg(CIB_IDX_IRQ_NUM, 8'h1F);
    rdreg(CIB_IDX_IRQ_TYPE, 8'h03);
  endtask : tUnimpl
  task automatic tWake();
    for (int k = 0; k < 3; k++)
    begin
      if (k == 1)
        wrreg(CIB_IDX_IRQ_NUM, 8'h0F);
      if (k == 2)
      begin
        wrreg(CIB_IDX_BANK, 8'h00);
        wrreg(CIB_IDX_ACTIVATE, 8'h00);
      end
      @(posedge clk);
      blockIrq <= (k == 2) ? 11'h001 : 11'h008;
      @(posedge clk);
      @(negedge clk);
      chk({5'h00, wakeEvent}, (k == 0) ? 16'h0008 : 16'h0000);
      @(posedge clk);
      blockIrq <= '0;
      @(negedge clk);
      chk({5'h00, wakeEvent}, 16'h0000);
    end
    chk({ioBase0Out[15:0]}, 16'h0000);
    chk({13'h0000, dmaChanOut[2:0]}, {13'h0000, CIB_DMA_NONE});
  endtask : tWake
  task automatic tStrap();
    doReset(1'b1, 1'b1);
    rdAt(base, CIB_INDEX_RST, 1'b1);
    chk({14'h0000, testMode, configBaseHigh}, 16'h0003);
    @(posedge clk);
    configBaseStrap <= 1'b0;
    rdAt(CIB_BASE_LOW, 8'h00, 1'b0);
    rdAt(base, CIB_INDEX_RST, 1'b1);
  endtask : tStrap
  // Cut-off well above the few hundred cycles the sequence needs
  initial
  begin
    repeat (4000) @(posedge clk);
    mismatches++;
    conclude();
  end
  initial
  begin
    doReset(1'b0, 1'b0);
    tAfterReset();
    tIndex();
    tBanks();
    tUnimpl();
    tWake();
    tStrap();
    conclude();
  end
endmodule : tb
`default_nettype wire
